// File: rtl/hcwf_framer.sv
// Contract
// - Split option: codes 1-7 use counter A, 8-15 counter B; else A.
// - Infrared mode: codes 12-15 count on counter B.
// - Infrared mode modulates the output with a 40 kHz carrier.
// - Seed enabled and code 9: send seed instead of hop code at once.
// - Seed enabled and code 3: normal words first, seed after a delay.
// - Each transmission: preamble, header, encrypted data, fixed data.
// - Payload is 67 bits: 32 encrypted then 35 fixed.
// - A guard period follows every transmission.
// - Cipher input: function, user, overflow, split, serial byte, counter.
// - Fixed part: low-voltage bit, CRC, function bits, 28-bit serial.
// - Long serial: full 32-bit serial replaces the function bits.
// - A started code word is finished unless a new button aborts it.
// - At least two transmissions; stop after button release.
// - Held button keeps transmissions repeating.
// - New button during transmission aborts and restarts a new word.
// - Skip option transmits only every second word.
// - CRC covers the 65 bits sent before it.
// - CRC starts at zero, updated bitwise per given equations.
// - Shutoff enabled: stop after about 25 s of continuous press.
// - Low-voltage bit sent each word, one while supply is low.
// - LED low while sending data, high during guard.
// - Low voltage: LED toggles at about 1 Hz during transmission.
`include "hcwf_defs.svh"
module hcwf_framer
  import hcwf_pkg::*;
#(
  parameter int PRE_CYC = 32,
  parameter int HDR_CYC = 16,
  parameter int BIT_CYC = 8,
  parameter int GUARD_CYC = 64,
  parameter int SEED_DELAY_WORDS = 28,
  parameter int SHUTOFF_CYC = `HCWF_SHUTOFF_CYC,
  parameter int LED_HALF = `HCWF_LED_HALF
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Buttons from pins
  input wire logic button_input_3_i,
  input wire logic button_input_2_i,
  input wire logic button_input_1_i,
  input wire logic button_input_0_i,
  // Configuration
  input wire logic split_counter_select_i,
  input wire logic skip_every_other_word_i,
  input wire logic auto_shutoff_enable_i,
  input wire logic long_serial_select_i,
  input wire logic seed_enable_i,
  input wire logic ir_mode_i,
  input wire logic overflow_i,
  input wire logic [1:0] user_bits_i,
  input wire logic [31:0] serial_i,
  input wire logic [31:0] seed_word_i,
  input wire logic low_voltage_i,
  // Cipher port: plaintext out, ciphertext back
  input wire logic [31:0] cipher_text_i,
  output logic [31:0] cipher_plain_o,
  // Line, indicator, busy flag and counter values
  output logic tx_data_o,
  output logic led_o,
  output logic busy_o,
  output logic [15:0] count_a_o,
  output logic [15:0] count_b_o
);
  hcwf_state_e state_ff, nxt_state;
  logic [3:0] btn_m_ff, btn_s_ff;
  logic lv_m_ff, lv_s_ff;
  logic [3:0] fn_ff;
  logic [66:0] word_ff;
  logic [6:0] bit_ff;
  logic [31:0] tmr_ff;
  logic [1:0] crc_ff;
  logic [1:0] sent_ff;
  logic skip_ff;
  logic [7:0] words_ff;
  logic [31:0] press_ff;
  logic [31:0] led_cnt_ff;
  logic led_tog_ff;
  logic [31:0] ir_cnt_ff;
  logic ir_ph_ff;
  logic [15:0] cnt_a_ff, cnt_b_ff;
  logic use_b_ff;

  // Counter choice by function code
  function automatic logic pick_b(input logic [3:0] fn, input logic split, input logic ir);
    pick_b = 1'b0;
    if (ir) begin
      pick_b = (fn >= `HCWF_FN_IR_LO);
    end else if (split) begin
      pick_b = (fn >= `HCWF_FN_SPLIT_LO);
    end
  endfunction

  // CRC step over one sent bit
  function automatic logic [1:0] crc_step(input logic [1:0] c, input logic d);
    crc_step = {c[0] ^ d, c[0] ^ d ^ c[1]};
  endfunction

  // Decoded button and control terms
  wire [3:0] btn_w = btn_s_ff;
  wire pressed_w = |btn_w;
  wire changed_w = pressed_w && (btn_w != fn_ff);
  wire seed_now_w = seed_enable_i && (fn_ff == `HCWF_FN_SEED_NOW);
  wire seed_late_w = seed_enable_i && (fn_ff == `HCWF_FN_SEED_LATE)
                     && (words_ff >= 8'(SEED_DELAY_WORDS));
  wire [15:0] sync_w = use_b_ff ? cnt_b_ff : cnt_a_ff;
  wire [31:0] hop_w = (seed_now_w || seed_late_w) ? seed_word_i : cipher_text_i;
  // Low-voltage bit 64, CRC slots 65 and 66 on top
  wire [34:0] fix_w = long_serial_select_i ?
                      {2'b00, lv_s_ff, serial_i} :
                      {2'b00, lv_s_ff, fn_ff, serial_i[27:0]};
  wire tmr_done_w = (tmr_ff == 32'd0);
  wire shut_w = auto_shutoff_enable_i && (press_ff >= 32'(SHUTOFF_CYC));
  wire last_bit_w = (bit_ff == 7'd66);
  wire more_w = pressed_w || (sent_ff < 2'd2);

  // Input synchronisers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      btn_m_ff <= 4'h0;
      btn_s_ff <= 4'h0;
      lv_m_ff <= 1'b0;
      lv_s_ff <= 1'b0;
    end else begin
      btn_m_ff <= {button_input_3_i, button_input_2_i, button_input_1_i, button_input_0_i};
      btn_s_ff <= btn_m_ff;
      lv_m_ff <= low_voltage_i;
      lv_s_ff <= lv_m_ff;
    end
  end

  // Next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      HCWF_IDLE: begin
        if (pressed_w) begin
          nxt_state = HCWF_LOAD;
        end
      end
      HCWF_LOAD: begin
        nxt_state = HCWF_PRE;
      end
      HCWF_PRE: begin
        if (changed_w) begin
          nxt_state = HCWF_LOAD;
        end else if (tmr_done_w) begin
          nxt_state = HCWF_DATA;
        end
      end
      HCWF_DATA: begin
        if (changed_w) begin
          nxt_state = HCWF_LOAD;
        end else if (tmr_done_w && last_bit_w) begin
          nxt_state = HCWF_GUARD;
        end
      end
      HCWF_GUARD: begin
        if (changed_w) begin
          nxt_state = HCWF_LOAD;
        end else if (tmr_done_w) begin
          if (shut_w) begin
            nxt_state = HCWF_HALT;
          end else if (more_w) begin
            nxt_state = HCWF_PRE;
          end else begin
            nxt_state = HCWF_IDLE;
          end
        end
      end
      HCWF_HALT: begin
        // Leaves only once every button is low
        if (!pressed_w) begin
          nxt_state = HCWF_IDLE;
        end
      end
      default: nxt_state = HCWF_IDLE;
    endcase
  end

  // Sequencer, framing and counters
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= HCWF_IDLE;
      fn_ff <= 4'h0;
      word_ff <= '0;
      bit_ff <= 7'd0;
      tmr_ff <= 32'd0;
      crc_ff <= 2'b00;
      sent_ff <= 2'd0;
      skip_ff <= 1'b0;
      words_ff <= 8'd0;
      cnt_a_ff <= 16'h0000;
      cnt_b_ff <= 16'h0000;
      use_b_ff <= 1'b0;
      cipher_plain_o <= 32'h0;
    end else begin
      state_ff <= nxt_state;
      if (tmr_ff != 32'd0) begin
        tmr_ff <= tmr_ff - 32'd1;
      end
      case (nxt_state)
        HCWF_LOAD: begin
          // Advance chosen counter once per activation
          fn_ff <= btn_w;
          use_b_ff <= pick_b(btn_w, split_counter_select_i, ir_mode_i);
          if (pick_b(btn_w, split_counter_select_i, ir_mode_i)) begin
            cnt_b_ff <= cnt_b_ff + 16'h0001;
          end else begin
            cnt_a_ff <= cnt_a_ff + 16'h0001;
          end
          sent_ff <= 2'd0;
          words_ff <= 8'd0;
          skip_ff <= 1'b0;
        end
        default: begin
        end
      endcase
      if (state_ff != HCWF_PRE && nxt_state == HCWF_PRE) begin
        tmr_ff <= 32'(PRE_CYC + HDR_CYC - 1);
        cipher_plain_o <= {fn_ff, user_bits_i, overflow_i, split_counter_select_i,
                           serial_i[7:0], sync_w};
      end
      if (state_ff == HCWF_PRE && nxt_state == HCWF_DATA) begin
        // Assemble 32 hop and 35 fixed bits
        word_ff <= {fix_w, hop_w};
        bit_ff <= 7'd0;
        crc_ff <= 2'b00;
        tmr_ff <= 32'(BIT_CYC - 1);
      end
      if (state_ff == HCWF_DATA && tmr_done_w && !last_bit_w) begin
        bit_ff <= bit_ff + 7'd1;
        tmr_ff <= 32'(BIT_CYC - 1);
        word_ff <= {1'b0, word_ff[66:1]};
        if (bit_ff < 7'd65) begin
          crc_ff <= crc_step(crc_ff, word_ff[0]);
        end
        // CRC fills the two slots that follow bit 64
        if (bit_ff == 7'd64) begin
          word_ff <= {1'b0, word_ff[66:3], crc_step(crc_ff, word_ff[0])};
        end
      end
      if (state_ff == HCWF_DATA && nxt_state == HCWF_GUARD) begin
        tmr_ff <= 32'(GUARD_CYC - 1);
        sent_ff <= (sent_ff == 2'd2) ? 2'd2 : sent_ff + 2'd1;
        if (words_ff != 8'hff) begin
          words_ff <= words_ff + 8'd1;
        end
        skip_ff <= ~skip_ff;
      end
    end
  end

  // Press time, LED flasher and IR carrier
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      press_ff <= 32'd0;
      led_cnt_ff <= 32'd0;
      led_tog_ff <= 1'b0;
      ir_cnt_ff <= 32'd0;
      ir_ph_ff <= 1'b0;
    end else begin
      press_ff <= (pressed_w && !changed_w) ?
                  ((press_ff == 32'hffffffff) ? press_ff : press_ff + 32'd1) : 32'd0;
      if (led_cnt_ff >= 32'(LED_HALF - 1)) begin
        led_cnt_ff <= 32'd0;
        led_tog_ff <= ~led_tog_ff;
      end else begin
        led_cnt_ff <= led_cnt_ff + 32'd1;
      end
      // 40 kHz carrier from the system clock
      if (ir_cnt_ff >= 32'(`HCWF_IR_HALF - 1)) begin
        ir_cnt_ff <= 32'd0;
        ir_ph_ff <= ~ir_ph_ff;
      end else begin
        ir_cnt_ff <= ir_cnt_ff + 32'd1;
      end
    end
  end

  // Line and LED values
  wire active_w = (state_ff == HCWF_PRE) || (state_ff == HCWF_DATA) ||
                  (state_ff == HCWF_GUARD);
  wire blank_w = skip_every_other_word_i && skip_ff;
  wire pre_bit_w = (tmr_ff >= 32'(HDR_CYC)) ? tmr_ff[0] : 1'b0;
  wire raw_w = blank_w ? 1'b0 :
               (state_ff == HCWF_PRE) ? pre_bit_w :
               (state_ff == HCWF_DATA) ? word_ff[0] : 1'b0;
  wire line_w = (ir_mode_i && raw_w) ? ir_ph_ff : raw_w;
  // LED low on data, high on guard
  wire led_norm_w = !(state_ff == HCWF_PRE || state_ff == HCWF_DATA);
  wire led_w = (state_ff == HCWF_HALT || !active_w) ? 1'b1 :
               lv_s_ff ? led_tog_ff : led_norm_w;

  // Registered outputs
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_data_o <= 1'b0;
      led_o <= 1'b1;
      busy_o <= 1'b0;
    end else begin
      tx_data_o <= line_w;
      led_o <= led_w;
      busy_o <= (state_ff != HCWF_IDLE);
    end
  end

  assign count_a_o = cnt_a_ff;
  assign count_b_o = cnt_b_ff;

  AST_SPLIT_PICK: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state_ff == HCWF_LOAD && !ir_mode_i && !split_counter_select_i) |-> !use_b_ff)
    else $error("Counter B chosen with split option clear");
  AST_FINISH: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state_ff == HCWF_DATA && !changed_w && !last_bit_w) |=> state_ff == HCWF_DATA)
    else $error("Code word left before completion");
  // Guard leads to idle only after two words
  AST_TWO_MIN: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state_ff == HCWF_GUARD && nxt_state == HCWF_IDLE) |-> sent_ff == 2'd2)
    else $error("Powered down before two words");
  AST_GUARD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ($rose(state_ff == HCWF_GUARD)) |-> tmr_ff == 32'(GUARD_CYC - 1))
    else $error("Guard period not loaded");
  AST_CRC0: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ($rose(state_ff == HCWF_DATA)) |-> crc_ff == 2'b00)
    else $error("CRC not cleared at word start");
  // Blanked slot keeps the line low
  AST_BLANK: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (skip_every_other_word_i && skip_ff && active_w) |=> !tx_data_o)
    else $error("Line driven during a blanked word");
endmodule

// File: rtl/hcwf_defs.svh
`ifndef HCWF_DEFS_SVH
`define HCWF_DEFS_SVH
// Code word layout
`define HCWF_WORD_BITS 67
`define HCWF_HOP_BITS 32
`define HCWF_FIX_BITS 35
`define HCWF_CRC_SPAN 65
// Timing figures
`define HCWF_CLK_HZ 20000000
`define HCWF_IR_HZ 40000
`define HCWF_IR_HALF ((`HCWF_CLK_HZ / `HCWF_IR_HZ) / 2)
`define HCWF_LED_HZ 1
`define HCWF_LED_HALF ((`HCWF_CLK_HZ / `HCWF_LED_HZ) / 2)
`define HCWF_SHUTOFF_S 25
`define HCWF_SHUTOFF_CYC (`HCWF_SHUTOFF_S * `HCWF_CLK_HZ)
// Function codes with special meaning
`define HCWF_FN_SEED_NOW 4'h9
`define HCWF_FN_SEED_LATE 4'h3
`define HCWF_FN_SPLIT_LO 4'h8
`define HCWF_FN_IR_LO 4'hc
`endif

// File: rtl/hcwf_pkg.sv
package hcwf_pkg;
  typedef enum logic [2:0] {
    HCWF_IDLE,
    HCWF_LOAD,
    HCWF_PRE,
    HCWF_DATA,
    HCWF_GUARD,
    HCWF_HALT
  } hcwf_state_e;
endpackage

// File: sim/hcwf_rx_model.sv
module hcwf_rx_model #(
  parameter int BASE = 48,
  parameter int BIT_CYC = 4,
  parameter int PERIOD = 332,
  parameter logic [31:0] MASK = 32'h5a3c_96e1
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Framer side
  input wire logic busy_i,
  input wire logic tx_data_i,
  input wire logic led_i,
  input wire logic [31:0] cipher_plain_i,
  output logic [31:0] cipher_text_o,
  // First and most recent word of a burst, LED in data and in guard
  output logic [66:0] word_o,
  output logic [66:0] last_o,
  output logic led_seen_o,
  output logic led_guard_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy_ff;
  logic arm_ff;
  int cnt_ff;
  int pos;
  int idx;
  // Stand-in cipher: a reversible mask, answered at once
  assign cipher_text_o = cipher_plain_i ^ MASK;
  // Word slots repeat every PERIOD cycles while the framer stays busy
  assign pos = (cnt_ff - BASE) % PERIOD;
  assign idx = pos / BIT_CYC;
  // Sample mid-bit so a one-cycle launch slip still lands inside the bit
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_ff <= 1'b0;
      arm_ff <= 1'b0;
      cnt_ff <= 0;
    end else begin
      busy_ff <= busy_i;
      if (busy_i && !busy_ff) begin
        arm_ff <= 1'b1;
        cnt_ff <= 0;
      end else if (!busy_i) begin
        arm_ff <= 1'b0;
      end else if (arm_ff) begin
        cnt_ff <= cnt_ff + 1;
        if (cnt_ff >= BASE && idx < 67 && pos % BIT_CYC == BIT_CYC / 2) begin
          last_o[idx] <= tx_data_i;
          if (cnt_ff < BASE + PERIOD) begin
            word_o[idx] <= tx_data_i;
          end
          if (cnt_ff == BASE + BIT_CYC / 2) begin
            led_seen_o <= led_i;
          end
        end
        // Guard sits between the last bit and the next preamble
        if (cnt_ff >= BASE && pos == 67 * BIT_CYC + BIT_CYC) begin
          led_guard_o <= led_i;
        end
      end
    end
  end
endmodule

// File: sim/testbench.sv
module testbench;
  import hcwf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] MASK = 32'h5a3c_96e1;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] btn = 4'h0;
  logic split = 1'b0, skip = 1'b0, shut = 1'b0, lng = 1'b0, seed = 1'b0, ir = 1'b0;
  logic lv = 1'b0;
  logic [31:0] ser = 32'h1234_5678;
  logic [31:0] sw = 32'hcafe_0123;
  logic [31:0] ct, pl;
  logic ovr = 1'b1;
  logic [1:0] usr = 2'h2;
  logic tx, led, busy, led_seen, led_guard;
  logic [15:0] ca, cb;
  logic [66:0] word, last;
  int err_total = 0, n_compared = 0, cyc = 0, hi;
  // 50 ns period
  always #25 clk_sys_i = ~clk_sys_i;
  hcwf_framer #(.PRE_CYC(32), .HDR_CYC(16), .BIT_CYC(4), .GUARD_CYC(16),
    .SEED_DELAY_WORDS(28), .SHUTOFF_CYC(2000), .LED_HALF(50)) uut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .button_input_3_i(btn[3]),
    .button_input_2_i(btn[2]), .button_input_1_i(btn[1]), .button_input_0_i(btn[0]),
    .split_counter_select_i(split), .skip_every_other_word_i(skip),
    .auto_shutoff_enable_i(shut), .long_serial_select_i(lng), .seed_enable_i(seed),
    .ir_mode_i(ir), .overflow_i(ovr), .user_bits_i(usr), .serial_i(ser),
    .seed_word_i(sw), .low_voltage_i(lv), .cipher_text_i(ct), .cipher_plain_o(pl),
    .tx_data_o(tx), .led_o(led), .busy_o(busy), .count_a_o(ca), .count_b_o(cb));
  // Slot: preamble and header, 67 bits, guard
  hcwf_rx_model #(.BASE(48), .BIT_CYC(4), .PERIOD(48 + 67 * 4 + 16), .MASK(MASK)) rx (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .busy_i(busy), .tx_data_i(tx),
    .led_i(led), .cipher_plain_i(pl), .cipher_text_o(ct), .word_o(word),
    .last_o(last), .led_seen_o(led_seen), .led_guard_o(led_guard));
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [66:0] seen, input logic [66:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      err_total++;
    end
  endtask
  // Two-bit code over the 65 bits ahead of it, in sent order
  function automatic logic [1:0] crc_of(input logic [66:0] w);
    logic c0, c1, d, n1;
    c0 = 1'b0;
    c1 = 1'b0;
    for (int i = 0; i <= 64; i++) begin
      d = w[i];
      n1 = c0 ^ d;
      c0 = c0 ^ d ^ c1;
      c1 = n1;
    end
    return {c1, c0};
  endfunction
  // Press, hold a few cycles (or longer), release, wait until idle
  task automatic run_press(input logic [3:0] fn, input int hold);
    @(negedge clk_sys_i) btn = fn;
    repeat (hold) @(negedge clk_sys_i);
    btn = 4'h0;
    hi = hold;
    while (busy === 1'b1 && hi < hold + 2000) begin
      @(negedge clk_sys_i);
      hi++;
    end
  endtask
  task automatic t_basic();
    logic [31:0] p;
    p = {4'h6, 2'h2, 1'b1, 1'b0, ser[7:0], 16'h0001};
    run_press(4'h6, 5);
    check(pl, p);
    check(word[31:0], p ^ MASK);
    check({word[63:60], word[59:32]}, {4'h6, ser[27:0]});
    check(word[64], 1'b0);
    check({word[66], word[65]}, crc_of(word));
    // Two slots of 48 + 268 + 16 cycles, a third would pass 996
    check({hi >= 664, hi < 996}, 2'b11);
    check(last, word);
    check({led_seen, led_guard}, 2'b01);
    $display("test basic done");
  endtask
  task automatic t_counters();
    logic [15:0] a, b;
    logic eb;
    for (int m = 0; m < 3; m++) begin
      split = (m == 1);
      ir = (m == 2);
      for (int f = 1; f < 16; f++) begin
        a = ca;
        b = cb;
        eb = (m == 1) ? (f >= 8) : (m == 2) ? (f >= 12) : 1'b0;
        run_press(f[3:0], 5);
        check({ca, cb}, {a + {15'h0, !eb}, b + {15'h0, eb}});
      end
    end
    split = 1'b0;
    ir = 1'b0;
    $display("test counters done");
  endtask
  task automatic t_long_seed();
    lng = 1'b1;
    lv = 1'b1;
    run_press(4'h5, 5);
    check({word[64], word[63:32]}, {1'b1, ser});
    check({word[66], word[65]}, crc_of(word));
    lng = 1'b0;
    lv = 1'b0;
    seed = 1'b1;
    run_press(4'h9, 5);
    check(word[31:0], sw);
    // Held past 28 words: the 29th slot carries the seed
    run_press(4'h3, 9500);
    check(word[31:0], {4'h3, 2'h2, 1'b1, 1'b0, ser[7:0], ca} ^ MASK);
    check(last[31:0], sw);
    seed = 1'b0;
    $display("test serial and seed done");
  endtask
  task automatic t_blank();
    logic [31:0] p;
    skip = 1'b1;
    ovr = 1'b0;
    usr = 2'h1;
    ser = 32'h0fed_cba9;
    run_press(4'h7, 5);
    p = {4'h7, 2'h1, 1'b0, 1'b0, ser[7:0], ca};
    check(pl, p);
    check(word[63:32], {4'h7, ser[27:0]});
    check(word[31:0], p ^ MASK);
    check(last, 67'h0);
    skip = 1'b0;
    ovr = 1'b1;
    usr = 2'h2;
    ser = 32'h1234_5678;
    $display("test blank done");
  endtask
  task automatic t_abort_hold();
    logic [15:0] a;
    logic dead;
    a = ca;
    @(negedge clk_sys_i) btn = 4'h2;
    repeat (150) @(negedge clk_sys_i);
    run_press(4'h5, 5);
    check({ca, pl[31:28]}, {a + 16'h0002, 4'h5});
    @(negedge clk_sys_i) btn = 4'h4;
    repeat (1700) @(negedge clk_sys_i);
    check(busy, 1'b1);
    run_press(4'h4, 1);
    shut = 1'b1;
    @(negedge clk_sys_i) btn = 4'h1;
    repeat (2600) @(negedge clk_sys_i);
    dead = 1'b0;
    repeat (400) @(negedge clk_sys_i) dead = dead | tx;
    check(dead, 1'b0);
    run_press(4'h1, 1);
    shut = 1'b0;
    $display("test abort hold shutoff done");
  endtask
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 70000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    t_basic();
    t_counters();
    t_long_seed();
    t_blank();
    t_abort_hold();
    wrap_up();
  end
endmodule
